// ==== rtl/ptq_consts.svh ====
`ifndef PTQ_CONSTS_SVH
`define PTQ_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets, byte addressed
// ----------------------------------------------------------------
`define PTQ_OFS_TAS_CTRL   12'h920
`define PTQ_OFS_EVT_INDEX  12'h923
`define PTQ_OFS_EVT_ENTRY  12'h924
`define PTQ_OFS_EVT_LAST   12'h927
`define PTQ_OFS_DROP       12'hA00
`define PTQ_OFS_DROP_LSB   12'hA03
`define PTQ_OFS_MEMBER     12'hA04
`define PTQ_OFS_MEMBER_LSB 12'hA07

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PTQ_CTRL_CT_BIT    7
`define PTQ_CTRL_RESTR_BIT 6
`define PTQ_CTRL_SEL_MSB   1
`define PTQ_EVT_CODE_MSB   31
`define PTQ_EVT_CODE_LSB   29
`define PTQ_EVT_TIME_MSB   28

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PTQ_RST_CTRL       8'h00
`define PTQ_RST_INDEX      7'h00
`define PTQ_RST_ENTRY      32'h0000_0000
`define PTQ_RST_DROP       2'h0
`define PTQ_RST_MEMBER     7'h7F

// ----------------------------------------------------------------
// shaper mode and timing
// ----------------------------------------------------------------
`define PTQ_SHAPER_TAS     2'h2
`define PTQ_SEC_NS         1000000000
`define PTQ_CLK_NS         40
`define PTQ_SEC_CYCLES     (`PTQ_SEC_NS / `PTQ_CLK_NS)

`endif

// ==== rtl/ptq_pkg.sv ====
package ptq_pkg;

  typedef enum logic [0:0] {
    PTQ_IDLE = 1'b0,
    PTQ_RUN  = 1'b1
  } ptq_state_type;

  typedef enum logic [2:0] {
    PTQ_EV_CLOSE  = 3'h0,
    PTQ_EV_GUARD  = 3'h1,
    PTQ_EV_OPEN   = 3'h2,
    PTQ_EV_REPEAT = 3'h7
  } ptq_evt_type;

  typedef enum logic [1:0] {
    PTQ_REF_NONE = 2'h0,
    PTQ_REF_FREE = 2'h1,
    PTQ_REF_PPS  = 2'h2,
    PTQ_REF_TIME = 2'h3
  } ptq_ref_type;

  typedef struct packed {
    logic        cut_through;
    logic        restricted;
    ptq_ref_type ref_sel;
  } ptq_ctrl_type;

  typedef struct packed {
    logic       valid;
    logic [1:0] prio;
    logic [2:0] dest;
    logic       congested;
  } ptq_pkt_type;

  typedef struct packed {
    logic drop;
    logic flow_ctrl;
    logic fwd_allow;
  } ptq_verdict_type;

endpackage : ptq_pkg

// ==== rtl/ptq_sched.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ptq_consts.svh"

module ptq_sched #(
  parameter int SEC_CYCLES = `PTQ_SEC_CYCLES
) (
  input  wire logic                 mclk_i,
  input  wire logic                 rst_i,
  input  wire ptq_pkg::ptq_ref_type ref_sel_i,
  input  wire logic                 pps_i,
  input  wire logic                 ref_cross_i,
  input  wire logic [6:0]           wr_index_i,
  input  wire logic                 wr_en_i,
  input  wire logic [1:0]           wr_lane_i,
  input  wire logic [7:0]           wr_data_i,
  output logic [31:0]               rd_entry_o,
  output logic                      gate_open_o,
  output logic                      guard_band_o
);
  import ptq_pkg::*;

  logic [31:0]   tbl [0:127];
  ptq_state_type state_reg;
  logic [28:0]   timer_reg;
  logic [6:0]    ev_idx_reg;
  logic [24:0]   sec_cnt_reg;
  logic          gate_reg;
  logic          guard_reg;

  // ----------------------------------------------------------------
  // entry access and start decode
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge_lane(input logic [31:0] old, input logic [1:0] lane,
                                             input logic [7:0] data);
    logic [31:0] res;
    res = old;
    res[(5'd24 - {lane, 3'b000}) +: 8] = data;
    return res;
  endfunction

  wire logic [31:0] cur_entry = tbl[ev_idx_reg];
  wire logic [2:0]  cur_code  = cur_entry[`PTQ_EVT_CODE_MSB:`PTQ_EVT_CODE_LSB];
  wire logic        sec_pulse = (sec_cnt_reg == 25'(SEC_CYCLES - 1));
  wire logic        start     = ((ref_sel_i == PTQ_REF_TIME) && ref_cross_i && (state_reg == PTQ_IDLE))
                             || ((ref_sel_i == PTQ_REF_PPS) && pps_i)
                             || ((ref_sel_i == PTQ_REF_FREE) && sec_pulse);
  wire logic        hit       = (state_reg == PTQ_RUN) && (timer_reg == cur_entry[`PTQ_EVT_TIME_MSB:0]);
  wire logic        restart   = hit && (cur_code == PTQ_EV_REPEAT);

  assign rd_entry_o   = tbl[wr_index_i];
  assign gate_open_o  = gate_reg;
  assign guard_band_o = guard_reg;

  // ----------------------------------------------------------------
  // event table
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 128; i++) begin
        tbl[i] <= `PTQ_RST_ENTRY;
      end
    end else if (wr_en_i) begin
      tbl[wr_index_i] <= merge_lane(tbl[wr_index_i], wr_lane_i, wr_data_i);
    end
  end

  // ----------------------------------------------------------------
  // one second pulse
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i || sec_pulse) begin
      sec_cnt_reg <= 25'h0000000;
    end else begin
      sec_cnt_reg <= sec_cnt_reg + 25'h0000001;
    end
  end

  // ----------------------------------------------------------------
  // schedule walker
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i || (ref_sel_i == PTQ_REF_NONE)) begin
      state_reg  <= PTQ_IDLE;
      timer_reg  <= 29'h00000000;
      ev_idx_reg <= 7'h00;
      gate_reg   <= 1'b0;
      guard_reg  <= 1'b0;
    end else if (start || restart) begin
      state_reg  <= PTQ_RUN;
      timer_reg  <= 29'h00000000;
      ev_idx_reg <= 7'h00;
    end else begin
      unique case (state_reg)
        PTQ_IDLE: begin
          timer_reg <= 29'h00000000;
        end
        PTQ_RUN: begin
          timer_reg <= timer_reg + 29'h00000001;
          if (hit) begin
            ev_idx_reg <= ev_idx_reg + 7'h01;
            unique case (cur_code)
              PTQ_EV_OPEN: begin
                gate_reg  <= 1'b1;
                guard_reg <= 1'b0;
              end
              PTQ_EV_GUARD: begin
                guard_reg <= 1'b1;
              end
              PTQ_EV_CLOSE: begin
                gate_reg  <= 1'b0;
                guard_reg <= 1'b0;
              end
              default: begin
              end
            endcase
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_repeat_restarts;
    @(posedge mclk_i) disable iff (rst_i)
      (restart && !start && ref_sel_i != PTQ_REF_NONE && $stable(ref_sel_i))
      |=> (timer_reg == 29'h00000000) && (ev_idx_reg == 7'h00);
  endproperty
  a_repeat_restarts: assert property (p_repeat_restarts) else $error("repeat did not restart");

  property p_open_event;
    @(posedge mclk_i) disable iff (rst_i)
      (hit && cur_code == PTQ_EV_OPEN && !start && ref_sel_i != PTQ_REF_NONE) |=> gate_open_o;
  endproperty
  a_open_event: assert property (p_open_event) else $error("open event missed");

  property p_no_ref_idle;
    @(posedge mclk_i) disable iff (rst_i)
      (ref_sel_i == PTQ_REF_NONE) |=> (state_reg == PTQ_IDLE) && !gate_open_o;
  endproperty
  a_no_ref_idle: assert property (p_no_ref_idle) else $error("schedule ran without reference");

endmodule // ptq_sched
`default_nettype wire

// ==== rtl/ptq_drop.sv ====
`timescale 1ns/1ps
`default_nettype none

module ptq_drop (
  input  wire logic                 mclk_i,
  input  wire logic                 rst_i,
  input  wire logic [1:0]           drop_mode_i,
  input  wire logic [6:0]           member_i,
  input  wire ptq_pkg::ptq_pkt_type pkt_i,
  output ptq_pkg::ptq_verdict_type  verdict_o
);
  import ptq_pkg::*;

  // ----------------------------------------------------------------
  // congestion and membership decode
  // ----------------------------------------------------------------
  wire logic       no_drop   = (drop_mode_i == 2'h0);
  wire logic       prio_hit  = ({1'b0, pkt_i.prio} < {1'b0, drop_mode_i});
  wire logic [2:0] dest_bit  = pkt_i.dest - 3'h1;
  wire logic       dest_ok   = (pkt_i.dest != 3'h0) && member_i[dest_bit];
  wire logic       cong      = pkt_i.valid && pkt_i.congested;

  ptq_verdict_type v_next;
  assign v_next.drop      = cong && !no_drop && prio_hit;
  assign v_next.flow_ctrl = cong && no_drop;
  assign v_next.fwd_allow = pkt_i.valid && dest_ok;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      verdict_o <= '0;
    end else begin
      verdict_o <= v_next;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_mode0_fc;
    @(posedge mclk_i) disable iff (rst_i)
      (cong && drop_mode_i == 2'h0) |=> verdict_o.flow_ctrl && !verdict_o.drop;
  endproperty
  a_mode0_fc: assert property (p_mode0_fc) else $error("mode 0 must only flow control");

  property p_mode1_drop;
    @(posedge mclk_i) disable iff (rst_i)
      (cong && drop_mode_i == 2'h1) |=> (verdict_o.drop == ($past(pkt_i.prio) == 2'h0)) && !verdict_o.flow_ctrl;
  endproperty
  a_mode1_drop: assert property (p_mode1_drop) else $error("mode 1 drop wrong");

  property p_mode2_drop;
    @(posedge mclk_i) disable iff (rst_i)
      (cong && drop_mode_i == 2'h2) |=> (verdict_o.drop == ($past(pkt_i.prio) <= 2'h1)) && !verdict_o.flow_ctrl;
  endproperty
  a_mode2_drop: assert property (p_mode2_drop) else $error("mode 2 drop wrong");

  property p_mode3_drop;
    @(posedge mclk_i) disable iff (rst_i)
      (cong && drop_mode_i == 2'h3) |=> (verdict_o.drop == ($past(pkt_i.prio) <= 2'h2)) && !verdict_o.flow_ctrl;
  endproperty
  a_mode3_drop: assert property (p_mode3_drop) else $error("mode 3 drop wrong");

  property p_member_block;
    @(posedge mclk_i) disable iff (rst_i)
      (pkt_i.valid && !dest_ok) |=> !verdict_o.fwd_allow;
  endproperty
  a_member_block: assert property (p_member_block) else $error("blocked port forwarded");

endmodule // ptq_drop
`default_nettype wire

// ==== rtl/ptq_port_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ptq_consts.svh"

module ptq_port_ctrl #(
  parameter int SEC_CYCLES = `PTQ_SEC_CYCLES
) (
  input  wire logic                 mclk_i,
  input  wire logic                 rst_i,
  input  wire logic [11:0]          reg_addr_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  input  wire logic [7:0]           reg_wdata_i,
  output logic [7:0]                reg_rdata_o,
  output logic                      reg_rvalid_o,
  input  wire logic [1:0]           shaper_mode_i,
  input  wire logic                 pps_i,
  input  wire logic                 ref_cross_i,
  input  wire ptq_pkg::ptq_pkt_type pkt_i,
  output ptq_pkg::ptq_verdict_type  verdict_o,
  output logic                      tx_allow_o,
  output logic                      cut_through_o,
  output logic                      gate_open_o,
  output logic                      guard_band_o
);
  import ptq_pkg::*;

  ptq_ctrl_type ctrl_reg;
  logic [6:0]   index_reg;
  logic [1:0]   drop_reg;
  logic [6:0]   member_reg;
  logic [31:0]  entry_rd;
  logic         gate_w;
  logic         guard_w;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire logic       sel_ctrl   = (reg_addr_i == `PTQ_OFS_TAS_CTRL);
  wire logic       sel_index  = (reg_addr_i == `PTQ_OFS_EVT_INDEX);
  wire logic       sel_entry  = (reg_addr_i >= `PTQ_OFS_EVT_ENTRY) && (reg_addr_i <= `PTQ_OFS_EVT_LAST);
  wire logic       sel_drop   = (reg_addr_i == `PTQ_OFS_DROP_LSB);
  wire logic       sel_member = (reg_addr_i == `PTQ_OFS_MEMBER_LSB);
  wire logic [1:0] lane       = reg_addr_i[1:0];
  wire logic       tas_mode   = (shaper_mode_i == `PTQ_SHAPER_TAS);

  // control byte to fields, shared by reset and write
  function automatic ptq_ctrl_type ctrl_from_byte(input logic [7:0] b);
    ptq_ctrl_type c;
    c.cut_through = b[`PTQ_CTRL_CT_BIT];
    c.restricted  = b[`PTQ_CTRL_RESTR_BIT];
    c.ref_sel     = ptq_ref_type'(b[`PTQ_CTRL_SEL_MSB:0]);
    return c;
  endfunction

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [7:0] rd_next;
  always_comb begin
    rd_next = 8'h00;
    if (sel_ctrl) begin
      rd_next = {ctrl_reg.cut_through, ctrl_reg.restricted, 4'h0, ctrl_reg.ref_sel};
    end else if (sel_index) begin
      rd_next = {1'b0, index_reg};
    end else if (sel_entry) begin
      rd_next = entry_rd[(5'd24 - {lane, 3'b000}) +: 8];
    end else if (sel_drop) begin
      rd_next = {6'h00, drop_reg};
    end else if (sel_member) begin
      rd_next = {1'b0, member_reg};
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ctrl_reg   <= ctrl_from_byte(`PTQ_RST_CTRL);
      index_reg  <= `PTQ_RST_INDEX;
      drop_reg   <= `PTQ_RST_DROP;
      member_reg <= `PTQ_RST_MEMBER;
    end else if (reg_wr_i) begin
      if (sel_ctrl) begin
        ctrl_reg <= ctrl_from_byte(reg_wdata_i);
      end
      if (sel_index) begin
        index_reg <= reg_wdata_i[6:0];
      end
      if (sel_drop) begin
        drop_reg <= reg_wdata_i[1:0];
      end
      if (sel_member) begin
        member_reg <= reg_wdata_i[6:0];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rdata_o  <= reg_rd_i ? rd_next : 8'h00;
      reg_rvalid_o <= reg_rd_i;
    end
  end

  // ----------------------------------------------------------------
  // schedule and forwarding
  // ----------------------------------------------------------------
  ptq_sched #(
    .SEC_CYCLES (SEC_CYCLES)
  ) u_sched (
    .mclk_i       (mclk_i),
    .rst_i        (rst_i),
    .ref_sel_i    (ctrl_reg.ref_sel),
    .pps_i        (pps_i),
    .ref_cross_i  (ref_cross_i),
    .wr_index_i   (index_reg),
    .wr_en_i      (reg_wr_i && sel_entry),
    .wr_lane_i    (lane),
    .wr_data_i    (reg_wdata_i),
    .rd_entry_o   (entry_rd),
    .gate_open_o  (gate_w),
    .guard_band_o (guard_w)
  );

  ptq_drop u_drop (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .drop_mode_i (drop_reg),
    .member_i    (member_reg),
    .pkt_i       (pkt_i),
    .verdict_o   (verdict_o)
  );

  // ----------------------------------------------------------------
  // transmit gating
  // ----------------------------------------------------------------
  wire logic tx_next = !tas_mode || !ctrl_reg.restricted || gate_w;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tx_allow_o    <= 1'b1;
      cut_through_o <= 1'b0;
      gate_open_o   <= 1'b0;
      guard_band_o  <= 1'b0;
    end else begin
      tx_allow_o    <= tx_next;
      cut_through_o <= tas_mode && ctrl_reg.cut_through;
      gate_open_o   <= gate_w;
      guard_band_o  <= guard_w;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_held;
    tas_mode && ctrl_reg.restricted && !gate_w;
  endsequence

  property p_restricted_hold;
    @(posedge mclk_i) disable iff (rst_i)
      s_held |=> !tx_allow_o;
  endproperty
  a_restricted_hold: assert property (p_restricted_hold) else $error("shaped packet sent while closed");

  property p_free_send;
    @(posedge mclk_i) disable iff (rst_i)
      !ctrl_reg.restricted |=> tx_allow_o;
  endproperty
  a_free_send: assert property (p_free_send) else $error("unrestricted send blocked");

  property p_non_tas;
    @(posedge mclk_i) disable iff (rst_i)
      !tas_mode |=> tx_allow_o && !cut_through_o;
  endproperty
  a_non_tas: assert property (p_non_tas) else $error("shaping applied to non tas queue");

  property p_cut_through;
    @(posedge mclk_i) disable iff (rst_i)
      (tas_mode && ctrl_reg.cut_through) |=> cut_through_o;
  endproperty
  a_cut_through: assert property (p_cut_through) else $error("cut-through not enabled");

  property p_index_read;
    @(posedge mclk_i) disable iff (rst_i)
      (reg_rd_i && sel_entry && lane == 2'h0) |=> reg_rvalid_o && (reg_rdata_o == $past(entry_rd[31:24]));
  endproperty
  a_index_read: assert property (p_index_read) else $error("event read wrong entry");

endmodule // ptq_port_ctrl
`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ptq_consts.svh"

module tb_top;
  import ptq_pkg::*;

  localparam int SECC = 50;

  logic            mclk_i;
  logic            rst_i;
  logic [11:0]     reg_addr_i;
  logic            reg_wr_i;
  logic            reg_rd_i;
  logic [7:0]      reg_wdata_i;
  logic [7:0]      reg_rdata_o;
  logic            reg_rvalid_o;
  logic [1:0]      shaper_mode_i;
  logic            pps_i;
  logic            ref_cross_i;
  ptq_pkt_type     pkt_i;
  ptq_verdict_type verdict_o;
  logic            tx_allow_o;
  logic            cut_through_o;
  logic            gate_open_o;
  logic            guard_band_o;
  int              err_total;
  int              samples_checked;

  ptq_port_ctrl #(.SEC_CYCLES(SECC)) i_dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .shaper_mode_i(shaper_mode_i), .pps_i(pps_i),
    .ref_cross_i(ref_cross_i), .pkt_i(pkt_i), .verdict_o(verdict_o), .tx_allow_o(tx_allow_o),
    .cut_through_o(cut_through_o), .gate_open_o(gate_open_o), .guard_band_o(guard_band_o)
  );

  // ----------------------------------------------------------------
  // clock, watchdog, verdict
  // ----------------------------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #(40 * 20000);
    err_total++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // compare and bus tasks
  // ----------------------------------------------------------------
  task automatic fail(input string m);
    err_total++;
    $display("MISMATCH t=%0t %s", $time, m);
  endtask

  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e, input string m);
    samples_checked++;
    if (g !== e) fail($sformatf("%s got %h exp %h", m, g, e));
  endtask

  task automatic chk_bit(input logic g, input logic e, input string m);
    samples_checked++;
    if (g !== e) fail($sformatf("%s got %b exp %b", m, g, e));
  endtask

  task automatic chk_int(input int g, input int e, input string m);
    samples_checked++;
    if (g != e) fail($sformatf("%s got %0d exp %0d", m, g, e));
  endtask

  task automatic chk_verdict(input ptq_verdict_type g, input ptq_verdict_type e);
    samples_checked++;
    if (g !== e) fail($sformatf("verdict got %b exp %b", g, e));
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i   <= 1'b0;
    #1;
    chk_bit(reg_rvalid_o, 1'b1, "rvalid");
    d = reg_rdata_o;
  endtask

  task automatic wr_entry(input logic [6:0] ix, input logic [31:0] v);
    wr(`PTQ_OFS_EVT_INDEX, {1'b0, ix});
    for (int b = 0; b < 4; b++) wr(`PTQ_OFS_EVT_ENTRY + 12'(b), v[31 - 8 * b -: 8]);
  endtask

  function automatic logic pick(input int w);
    return (w == 0) ? gate_open_o : guard_band_o;
  endfunction

  task automatic wait_lvl(input int w, input logic v, input int lim, output int n);
    #1;
    n = 0;
    while (pick(w) !== v && n < lim) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    if (n >= lim) fail("wait limit");
  endtask

  task automatic pulse(input int w);
    @(posedge mclk_i);
    if (w == 0) pps_i <= 1'b1; else ref_cross_i <= 1'b1;
    @(posedge mclk_i);
    pps_i       <= 1'b0;
    ref_cross_i <= 1'b0;
  endtask

  task automatic settle_chk(input logic g, input logic t, input string m);
    repeat (4) @(posedge mclk_i);
    #1;
    chk_bit(gate_open_o, g, m);
    chk_bit(tx_allow_o, t, m);
  endtask

  function automatic ptq_verdict_type exp_v(input logic [1:0] md, input logic [6:0] mb, input ptq_pkt_type p);
    ptq_verdict_type v;
    v.drop      = p.congested && (p.prio < md);
    v.flow_ctrl = p.congested && (md == 2'h0);
    v.fwd_allow = (p.dest != 3'h0) && mb[p.dest - 3'h1];
    return v;
  endfunction

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  logic [11:0] ra[9] = '{12'h920, 12'h923, 12'h924, 12'h925, 12'h926, 12'h927, 12'hA00, 12'hA03, 12'h930};
  logic [7:0]  d;
  logic [6:0]  ix[4];
  logic [31:0] ev[4];
  logic [1:0]  md;
  logic [6:0]  mb;
  ptq_pkt_type p;
  int          n;

  initial begin
    err_total = 0;
    samples_checked = 0;
    rst_i = 1'b1;
    reg_addr_i = 12'h000;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_wdata_i = 8'h00;
    shaper_mode_i = 2'h0;
    pps_i = 1'b0;
    ref_cross_i = 1'b0;
    pkt_i = '0;
    void'($urandom(70));
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;

    wr(12'h930, 8'hFF);
    foreach (ra[k]) begin
      rd(ra[k], d);
      chk_byte(d, 8'h00, "reset value");
    end
    rd(`PTQ_OFS_MEMBER_LSB, d);
    chk_byte(d, 8'h7F, "member reset");
    $display("test reset done");

    shaper_mode_i <= 2'h2;
    wr(`PTQ_OFS_TAS_CTRL, 8'hFF);
    rd(`PTQ_OFS_TAS_CTRL, d);
    chk_byte(d, 8'hC3, "ctrl rw");
    chk_bit(cut_through_o, 1'b1, "cut through on");
    wr(`PTQ_OFS_TAS_CTRL, 8'h00);
    rd(`PTQ_OFS_EVT_INDEX, d);
    chk_bit(cut_through_o, 1'b0, "cut through off");
    for (int k = 0; k < 4; k++) begin
      ix[k] = 7'(16 + 32 * k + $urandom % 16);
      ev[k] = $urandom;
      wr_entry(ix[k], ev[k]);
    end
    for (int k = 0; k < 4; k++) begin
      wr(`PTQ_OFS_EVT_INDEX, {1'b1, ix[k]});
      rd(`PTQ_OFS_EVT_INDEX, d);
      chk_byte(d, {1'b0, ix[k]}, "index");
      for (int b = 0; b < 4; b++) begin
        rd(`PTQ_OFS_EVT_ENTRY + 12'(b), d);
        chk_byte(d, ev[k][31 - 8 * b -: 8], "entry byte");
      end
    end
    $display("test registers done");

    for (int i = 0; i < 40; i++) begin
      md = (i == 0) ? 2'h0 : (i == 1) ? 2'h3 : 2'($urandom);
      mb = (i == 0) ? 7'h7F : (i == 1) ? 7'h00 : 7'($urandom);
      wr(`PTQ_OFS_DROP_LSB, {6'h3F, md});
      wr(`PTQ_OFS_MEMBER_LSB, {1'b1, mb});
      rd(`PTQ_OFS_MEMBER_LSB, d);
      chk_byte(d, {1'b0, mb}, "member rw");
      for (int j = 0; j < 4; j++) begin
        p = '{valid: 1'b1, prio: 2'($urandom), dest: 3'($urandom), congested: 1'($urandom)};
        @(posedge mclk_i);
        pkt_i <= p;
        @(posedge mclk_i);
        #1;
        chk_verdict(verdict_o, exp_v(md, mb, p));
      end
    end
    @(posedge mclk_i);
    pkt_i <= '0;
    $display("test drop done");

    shaper_mode_i <= 2'h2;
    wr_entry(7'h00, {PTQ_EV_OPEN, 29'h5});
    wr_entry(7'h01, {3'h5, 29'hA});
    wr_entry(7'h02, {PTQ_EV_GUARD, 29'h14});
    wr_entry(7'h03, {PTQ_EV_CLOSE, 29'h19});
    wr_entry(7'h04, {PTQ_EV_REPEAT, 29'h28});
    wr(`PTQ_OFS_TAS_CTRL, 8'h42);
    settle_chk(1'b0, 1'b0, "held before pps");
    pulse(0);
    wait_lvl(0, 1'b1, 60, n);
    @(posedge mclk_i);
    #1;
    chk_bit(tx_allow_o, 1'b1, "open allows tx");
    wait_lvl(1, 1'b1, 40, n);
    chk_int(n, 14, "guard after open");
    wait_lvl(0, 1'b0, 40, n);
    chk_int(n, 5, "close after guard");
    wait_lvl(0, 1'b1, 60, n);
    $display("test schedule done");

    wr(`PTQ_OFS_TAS_CTRL, 8'h40);
    settle_chk(1'b0, 1'b0, "no reference");
    for (int k = 0; k < 60; k++) begin
      @(posedge mclk_i);
      #1;
      chk_bit(gate_open_o, 1'b0, "idle stays closed");
    end
    wr(`PTQ_OFS_TAS_CTRL, 8'h41);
    wait_lvl(0, 1'b1, 3 * SECC, n);
    wr(`PTQ_OFS_TAS_CTRL, 8'h40);
    wr(`PTQ_OFS_TAS_CTRL, 8'h43);
    settle_chk(1'b0, 1'b0, "wait for crossing");
    pulse(1);
    wait_lvl(0, 1'b1, 60, n);
    wr(`PTQ_OFS_TAS_CTRL, 8'h00);
    settle_chk(1'b0, 1'b1, "unrestricted");
    wr(`PTQ_OFS_TAS_CTRL, 8'hC0);
    shaper_mode_i <= 2'h0;
    settle_chk(1'b0, 1'b1, "not shaped");
    chk_bit(cut_through_o, 1'b0, "not shaped ct");
    $display("test reference done");

    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(`PTQ_OFS_MEMBER_LSB, d);
    chk_byte(d, 8'h7F, "member after reset");
    rd(`PTQ_OFS_TAS_CTRL, d);
    chk_byte(d, 8'h00, "ctrl after reset");
    rd(`PTQ_OFS_EVT_ENTRY, d);
    chk_byte(d, 8'h00, "entry after reset");
    $display("test midrun reset done");
    report_and_stop();
  end
endmodule // tb_top

`default_nettype wire
